/* hw/ltc_pkg.sv */
// Shared constants and types of the line trim control and status block
package ltc_pkg;

	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned SETTLE_LONG_MS  = 300;
	localparam int unsigned SETTLE_SHORT_MS = 30;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned ADDR_W          = 12;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_ONE = 8'h60;
	localparam logic [7:0] IDX_CTRL_TWO = 8'h61;
	localparam logic [7:0] IDX_RING_RES = 8'h62;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
	localparam logic [7:0] IDX_NONE     = 8'hFF;

	// Control register one fields
	localparam int unsigned CAL_BIT     = 6;
	localparam int unsigned SHORTEN_BIT = 5;

	// Sub-calibration vector: 0 current limit, 1 common mode, 2 differential,
	// 3 tip, 4 ring, 5 audio ADC, 6 audio DAC, 7 monitor two, 8 monitor one
	localparam int unsigned NSUB         = 9;
	localparam int unsigned SUB_RING     = 4;
	localparam logic [8:0]  OFFSET_MASK  = 9'h060;

	localparam int unsigned RES_W        = 5;
	localparam logic [4:0]  RING_RES_RST = 5'h10;

	localparam int unsigned IRQ_W        = 3;
	localparam int unsigned IRQ_SYS_DONE = 0;
	localparam int unsigned IRQ_OFS_DONE = 1;
	localparam int unsigned IRQ_SUB_DONE = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SETTLE  = 2'b01,
		ST_RUN     = 2'b10,
		ST_RELEASE = 2'b11
	} ltc_seq_t;

endpackage : ltc_pkg

/* hw/ltc_settle_timer.sv */
// Battery settling interval timer with a millisecond enable divider
`timescale 1ns/1ps
`default_nettype none
module ltc_settle_timer #(
	parameter int unsigned CYC_PER_MS = ltc_pkg::CYC_PER_MS,
	parameter int unsigned LONG_MS    = ltc_pkg::SETTLE_LONG_MS,
	parameter int unsigned SHORT_MS   = ltc_pkg::SETTLE_SHORT_MS
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic shorten,
	output logic      done
);
	import ltc_pkg::*;

	localparam int unsigned CW = $clog2(CYC_PER_MS + 1);
	localparam int unsigned MW = 16;

	typedef struct packed {
		logic [CW-1:0] div;
		logic [MW-1:0] ms;
		logic [MW-1:0] target;
		logic          active;
		logic          done;
	} ltc_tmr_state_t;

	ltc_tmr_state_t r_reg;
	ltc_tmr_state_t r_next;
	logic           tick;

	assign tick = r_reg.active && (r_reg.div == CW'(CYC_PER_MS - 1));
	assign done = r_reg.done;

	always_comb begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		if (start) begin
			r_next.active = 1'b1;
			r_next.div    = '0;
			r_next.ms     = '0;
			r_next.target = shorten ? MW'(SHORT_MS) : MW'(LONG_MS);
		end else if (r_reg.active) begin
			if (tick) begin
				r_next.div = '0;
				if (r_reg.ms == r_reg.target - MW'(1)) begin
					r_next.active = 1'b0;
					r_next.done   = 1'b1;
				end else begin
					r_next.ms = r_reg.ms + MW'(1);
				end
			end else begin
				r_next.div = r_reg.div + CW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_settle_long: assert property (start && !shorten |=> r_reg.target == MW'(LONG_MS))
		else $error("long settling interval not selected");
	a_settle_short: assert property (start && shorten |=> r_reg.target == MW'(SHORT_MS))
		else $error("short settling interval not selected");
	a_settle_end: assert property (done |-> $past(r_reg.ms) == $past(r_reg.target) - MW'(1))
		else $error("settling ended before its interval");

endmodule : ltc_settle_timer
`default_nettype wire

/* hw/ltc_trim_regs.sv */
// Calibration control and status registers with sequencer and AXI4-Lite slave
//
// Behaviour
// - Writing one to bit 6 starts full calibration; reads one until it ends.
// - Settle-shorten bit picks 300 ms settling when clear, 30 ms when set.
// - Ring mismatch bit 4 enables that calibration; reads one while enabled or running.
// - Tip mismatch bit 3 enables that calibration; reads one until it is done.
// - Bits 2, 1, 0 read one while their calibration is enabled or running.
// - Monitor converter bits 4 and 3 of register two read one until done.
// - Writing one to audio DAC bit starts its offset calibration; one until done.
// - Writing one to audio ADC bit starts its offset calibration; one until done.
// - Ring result holds a read/write 5-bit trim, reset 0x10, upper bits zero.
`timescale 1ns/1ps
`default_nettype none
module ltc_trim_regs #(
	parameter int unsigned CYC_PER_MS = ltc_pkg::CYC_PER_MS,
	parameter int unsigned ADDR_W     = ltc_pkg::ADDR_W
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [ltc_pkg::NSUB-1:0]       cal_req,
	input  wire logic                      cal_done,
	input  wire logic [ltc_pkg::RES_W-1:0] cal_result,
	output logic [ltc_pkg::RES_W-1:0]      ring_trim_value,
	output logic                           irq
);
	import ltc_pkg::*;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              aw_got;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              w_got;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		ltc_seq_t          st;
		logic              sys_mode;
		logic              cal_busy;
		logic              shorten;
		logic [NSUB-1:0]   sub;
		logic [3:0]        cur;
		logic [NSUB-1:0]   req;
		logic [RES_W-1:0]  ring_res;
		logic [IRQ_W-1:0]  irq_stat;
		logic [IRQ_W-1:0]  irq_mask;
		logic              irq;
		logic              done_m;
		logic              done_s;
		logic [RES_W-1:0]  res_m;
		logic [RES_W-1:0]  res_s;
	} ltc_state_t;

	ltc_state_t      r_reg;
	ltc_state_t      r_next;
	logic            settle_start;
	logic            settle_done;
	logic            wr_do;
	logic            wr_en;
	logic [7:0]      wr_idx;
	logic [7:0]      rd_idx;
	logic [NSUB-1:0] pend;

	// Misaligned or out-of-window addresses decode to no register
	function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
		if (a[ADDR_W-1:10] == '0 && a[1:0] == 2'b00) begin
			reg_idx = a[9:2];
		end else begin
			reg_idx = IDX_NONE;
		end
	endfunction : reg_idx

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == IDX_CTRL_ONE) || (idx == IDX_CTRL_TWO) || (idx == IDX_RING_RES)
			|| (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
	endfunction : is_mapped

	function automatic logic [3:0] pick_low(input logic [NSUB-1:0] v);
		pick_low = '0;
		for (int i = NSUB - 1; i >= 0; i--) begin
			if (v[i]) begin
				pick_low = 4'(i);
			end
		end
	endfunction : pick_low

	assign wr_do  = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
	assign wr_idx = reg_idx(r_reg.awaddr);
	assign wr_en  = wr_do && r_reg.wstrb[0];
	assign rd_idx = reg_idx(s_axi_araddr);
	assign pend   = r_reg.sys_mode ? r_reg.sub : (r_reg.sub & OFFSET_MASK);

	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] w1c;
		ev           = '0;
		w1c          = '0;
		r_next       = r_reg;
		settle_start = 1'b0;

		r_next.done_m = cal_done;
		r_next.done_s = r_reg.done_m;
		r_next.res_m  = cal_result;
		r_next.res_s  = r_reg.res_m;

		// Address and data are taken in either order; the reply waits for both
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.awaddr = s_axi_awaddr;
			r_next.aw_got = 1'b1;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.wdata  = s_axi_wdata;
			r_next.wstrb  = s_axi_wstrb;
			r_next.w_got  = 1'b1;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (wr_do) begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end

		// Control writes are ignored while a calibration is running
		if (wr_en && r_reg.st == ST_IDLE) begin
			if (wr_idx == IDX_CTRL_ONE) begin
				r_next.cal_busy = r_reg.cal_busy | r_reg.wdata[CAL_BIT];
				r_next.shorten  = r_reg.wdata[SHORTEN_BIT];
				r_next.sub[4:0] = r_reg.wdata[4:0];
			end
			if (wr_idx == IDX_CTRL_TWO) begin
				r_next.sub[8:5] = r_reg.wdata[4:1];
			end
		end
		if (wr_en && wr_idx == IDX_RING_RES) begin
			r_next.ring_res = r_reg.wdata[RES_W-1:0];
		end
		if (wr_en && wr_idx == IDX_IRQ_MASK) begin
			r_next.irq_mask = r_reg.wdata[IRQ_W-1:0];
		end
		if (wr_en && wr_idx == IDX_IRQ_STAT) begin
			w1c = r_reg.wdata[IRQ_W-1:0];
		end

		unique case (r_reg.st)
			ST_IDLE: begin
				if (r_reg.cal_busy) begin
					r_next.st       = ST_SETTLE;
					r_next.sys_mode = 1'b1;
					settle_start    = 1'b1;
				end else if ((r_reg.sub & OFFSET_MASK) != '0) begin
					r_next.st       = ST_RUN;
					r_next.sys_mode = 1'b0;
				end
			end
			ST_SETTLE: begin
				if (settle_done) begin
					r_next.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (pend == '0) begin
					r_next.st = ST_IDLE;
					r_next.req = '0;
					if (r_reg.sys_mode) begin
						r_next.cal_busy   = 1'b0;
						ev[IRQ_SYS_DONE] = 1'b1;
					end else begin
						ev[IRQ_OFS_DONE] = 1'b1;
					end
				end else if (r_reg.req == '0) begin
					r_next.cur = pick_low(pend);
					r_next.req = NSUB'(1) << pick_low(pend);
				end else if (r_reg.done_s) begin
					// Trim circuit answered: retire this lane and wait for its done to drop
					r_next.sub[r_reg.cur] = 1'b0;
					r_next.req            = '0;
					r_next.st             = ST_RELEASE;
					ev[IRQ_SUB_DONE]      = 1'b1;
					if (r_reg.cur == 4'(SUB_RING)) begin
						r_next.ring_res = r_reg.res_s;
					end
				end
			end
			ST_RELEASE: begin
				if (!r_reg.done_s) begin
					r_next.st = ST_RUN;
				end
			end
		endcase

		// Set wins over a simultaneous write-one clear
		r_next.irq_stat = (r_reg.irq_stat & ~w1c) | ev;
		r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);

		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			r_next.rdata  = '0;
			unique case (rd_idx)
				IDX_CTRL_ONE: r_next.rdata[6:0] = {r_reg.cal_busy, r_reg.shorten, r_reg.sub[4:0]};
				IDX_CTRL_TWO: r_next.rdata[4:1] = r_reg.sub[8:5];
				IDX_RING_RES: r_next.rdata[RES_W-1:0] = r_reg.ring_res;
				IDX_IRQ_STAT: r_next.rdata[IRQ_W-1:0] = r_reg.irq_stat;
				IDX_IRQ_MASK: r_next.rdata[IRQ_W-1:0] = r_reg.irq_mask;
				default: r_next.rdata = '0;
			endcase
		end

		r_next.awready = !r_next.aw_got && !r_next.bvalid;
		r_next.wready  = !r_next.w_got && !r_next.bvalid;
		r_next.arready = !r_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg          <= '0;
			r_reg.st       <= ST_IDLE;
			r_reg.ring_res <= RING_RES_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	ltc_settle_timer #(
		.CYC_PER_MS (CYC_PER_MS),
		.LONG_MS    (SETTLE_LONG_MS),
		.SHORT_MS   (SETTLE_SHORT_MS)
	) u_settle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (settle_start),
		.shorten (r_reg.shorten),
		.done    (settle_done)
	);

	assign s_axi_awready   = r_reg.awready;
	assign s_axi_wready    = r_reg.wready;
	assign s_axi_bvalid    = r_reg.bvalid;
	assign s_axi_bresp     = r_reg.bresp;
	assign s_axi_arready   = r_reg.arready;
	assign s_axi_rvalid    = r_reg.rvalid;
	assign s_axi_rdata     = r_reg.rdata;
	assign s_axi_rresp     = r_reg.rresp;
	assign cal_req         = r_reg.req;
	assign ring_trim_value = r_reg.ring_res;
	assign irq             = r_reg.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sys_write;
		wr_en && wr_idx == IDX_CTRL_ONE && r_reg.wdata[CAL_BIT] && r_reg.st == ST_IDLE;
	endsequence
	sequence s_lane_answer;
		r_reg.st == ST_RUN && r_reg.req != '0 && r_reg.done_s && pend != '0;
	endsequence

	a_sys_start: assert property (s_sys_write |=> r_reg.cal_busy ##1 r_reg.st == ST_SETTLE)
		else $error("full calibration did not start");
	a_sys_finish: assert property (r_reg.st == ST_RUN && r_reg.sys_mode && pend == '0
		|=> !r_reg.cal_busy && r_reg.irq_stat[IRQ_SYS_DONE])
		else $error("calibration bit not cleared at completion");
	a_lane_retire: assert property (s_lane_answer |=> !r_reg.sub[$past(r_reg.cur)]
		&& r_reg.st == ST_RELEASE)
		else $error("finished calibration bit not cleared");
	a_lane_hold: assert property (r_reg.st == ST_RUN && r_reg.req != '0 && !r_reg.done_s
		&& pend != '0 |=> r_reg.sub[$past(r_reg.cur)])
		else $error("calibration bit dropped before done");
	a_ring_capture: assert property (s_lane_answer and (r_reg.cur == 4'(SUB_RING))
		|=> r_reg.ring_res == $past(r_reg.res_s))
		else $error("ring trim result not stored");
	a_offset_start: assert property (r_reg.st == ST_IDLE && !r_reg.cal_busy
		&& (r_reg.sub & OFFSET_MASK) != '0 |=> r_reg.st == ST_RUN && !r_reg.sys_mode)
		else $error("offset calibration did not start");
	a_reserved_one: assert property (s_axi_arvalid && r_reg.arready && rd_idx == IDX_CTRL_ONE
		|=> r_reg.rdata[31:7] == '0)
		else $error("reserved bits of control one not zero");
	a_reserved_two: assert property (s_axi_arvalid && r_reg.arready && rd_idx == IDX_CTRL_TWO
		|=> r_reg.rdata[31:5] == '0 && !r_reg.rdata[0])
		else $error("reserved bits of control two not zero");
	a_result_upper: assert property (s_axi_arvalid && r_reg.arready && rd_idx == IDX_RING_RES
		|=> r_reg.rdata[31:RES_W] == '0 && r_reg.rdata[RES_W-1:0] == $past(r_reg.ring_res))
		else $error("ring result readback wrong");
	a_irq_level: assert property (r_reg.irq == |($past(r_next.irq_stat) & $past(r_next.irq_mask)))
		else $error("interrupt level does not follow status and mask");

endmodule : ltc_trim_regs
`default_nettype wire

/* dv/test_line_trim_control_status.sv */
// Self-checking bench for the trim control and status register block
`timescale 1ns/1ps
`default_nettype none
module test_line_trim_control_status;
	import ltc_pkg::*;
	localparam int unsigned CPM    = 4;
	localparam int          LIMIT  = 20000;
	localparam logic [11:0] A_ONE  = {2'b00, IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] A_TWO  = {2'b00, IDX_CTRL_TWO, 2'b00};
	localparam logic [11:0] A_RES  = {2'b00, IDX_RING_RES, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, cal_done;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [8:0]  cal_req;
	logic [4:0]  cal_result, ring_trim_value, rnd, saved, rem1;
	logic [1:0]  rem2;
	int          fails, checks, cyc, t0, n;
	int          lanes [7] = '{0, 1, 2, 3, 4, 7, 8};

	ltc_trim_regs #(.CYC_PER_MS(CPM), .ADDR_W(12)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cal_req(cal_req),
		.cal_done(cal_done), .cal_result(cal_result),
		.ring_trim_value(ring_trim_value), .irq(irq)
	);

	always #2.5 aclk = ~aclk;

	function automatic logic [31:0] lane_bit(input int lane);
		return 32'h1 << lane;
	endfunction : lane_bit

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// Watchdog: the longest test is the 300 ms settle, about 1200 cycles here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails = fails + 1;
			final_report();
		end
	end

	task automatic cmp_data(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_data

	task automatic cmp_resp(input string what, input logic [1:0] e, input logic [1:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_resp

	task automatic cmp_bit(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask : cmp_bit

	task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axi_read

	// Acts as the trim circuit: answers one lane request and keeps the result steady
	task automatic serve(input int lane, input logic [4:0] res);
		while (cal_req === 9'h000) @(posedge aclk);
		cmp_data("cal_req", lane_bit(lane), {23'h0, cal_req});
		cal_result <= res;
		cal_done <= 1'b1;
		while (cal_req !== 9'h000) @(posedge aclk);
		cal_done <= 1'b0;
		@(posedge aclk);
	endtask : serve

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, cal_done} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		cal_result = '0;
		fails = 0;
		checks = 0;
		cyc = 0;
		void'($urandom(32'h8BF6));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);

		axi_read(A_ONE, d, r);
		cmp_data("ctrl one", 32'h0, d);
		axi_read(A_TWO, d, r);
		cmp_data("ctrl two", 32'h0, d);
		axi_read(A_RES, d, r);
		cmp_data("ring result", 32'h10, d);
		cmp_data("ring trim", 32'h10, {27'h0, ring_trim_value});
		cmp_bit("irq", 1'b0, irq);
		axi_read(12'h18C, d, r);
		cmp_resp("unmapped read resp", RESP_SLVERR, r);
		cmp_data("unmapped read data", 32'h0, d);
		axi_write(12'h300, 32'hFF, r);
		cmp_resp("unmapped write resp", RESP_SLVERR, r);
		$display("TEST reset and map done");

		rnd = 5'($urandom);
		axi_write(A_RES, 32'hFFFF_FFE0 | {27'h0, rnd}, r);
		cmp_resp("result write resp", RESP_OKAY, r);
		axi_read(A_RES, d, r);
		cmp_data("ring result rw", {27'h0, rnd}, d);
		cmp_data("ring trim rw", {27'h0, rnd}, {27'h0, ring_trim_value});
		// Low byte strobe off makes the write void
		wstrb <= 4'hE;
		axi_write(A_RES, 32'h0, r);
		wstrb <= 4'hF;
		axi_read(A_RES, d, r);
		cmp_data("ring result void write", {27'h0, rnd}, d);
		$display("TEST ring result done");

		// Reserved bits written as ones; only the offset lanes start
		axi_write(A_TWO, 32'hFF, r);
		axi_read(A_TWO, d, r);
		cmp_data("ctrl two start", 32'h1E, d);
		serve(5, 5'($urandom));
		axi_read(A_TWO, d, r);
		cmp_data("ctrl two adc done", 32'h1C, d);
		serve(6, 5'($urandom));
		axi_read(A_TWO, d, r);
		cmp_data("ctrl two dac done", 32'h18, d);
		// The offset-done event lands a few cycles after the last lane lets go
		do axi_read(A_STAT, d, r); while (d[IRQ_OFS_DONE] !== 1'b1);
		cmp_data("irq status offset", 32'h6, d);
		cmp_bit("irq masked", 1'b0, irq);
		axi_write(A_MASK, 32'h2, r);
		@(posedge aclk);
		cmp_bit("irq unmasked", 1'b1, irq);
		axi_write(A_STAT, 32'h7, r);
		@(posedge aclk);
		cmp_bit("irq cleared", 1'b0, irq);
		axi_read(A_STAT, d, r);
		cmp_data("irq status cleared", 32'h0, d);
		axi_write(A_MASK, 32'h7, r);
		$display("TEST offset calibration done");

		axi_write(A_ONE, 32'hFF, r);
		t0 = cyc;
		axi_read(A_ONE, d, r);
		cmp_data("ctrl one busy", 32'h7F, d);
		// Control writes during a run are ignored
		axi_write(A_ONE, 32'h00, r);
		cmp_resp("busy write resp", RESP_OKAY, r);
		axi_write(A_TWO, 32'h06, r);
		axi_read(A_TWO, d, r);
		cmp_data("ctrl two while busy", 32'h18, d);
		while (cal_req === 9'h000) @(posedge aclk);
		n = cyc - t0;
		cmp_bit("short settle", 1'b1, n >= 30 * CPM - 2 && n <= 30 * CPM + 10);
		rem1 = 5'h1F;
		rem2 = 2'b11;
		foreach (lanes[i]) begin
			rnd = 5'($urandom);
			serve(lanes[i], rnd);
			if (lanes[i] < 5)
				rem1[lanes[i]] = 1'b0;
			else
				rem2[lanes[i] - 7] = 1'b0;
			if (lanes[i] == SUB_RING)
				saved = rnd;
			axi_read(A_ONE, d, r);
			cmp_data("ctrl one lanes", {27'h0, rem1}, d & 32'h1F);
			axi_read(A_TWO, d, r);
			cmp_data("ctrl two lanes", {27'h0, rem2, 3'h0}, d);
		end
		do axi_read(A_ONE, d, r); while (d[6] !== 1'b0);
		cmp_data("ctrl one idle", 32'h20, d);
		axi_read(A_RES, d, r);
		cmp_data("ring captured", {27'h0, saved}, d);
		cmp_data("ring trim captured", {27'h0, saved}, {27'h0, ring_trim_value});
		axi_read(A_STAT, d, r);
		cmp_data("irq status full", 32'h5, d);
		cmp_bit("irq full", 1'b1, irq);
		axi_write(A_STAT, 32'h7, r);
		$display("TEST full calibration done");

		axi_write(A_ONE, 32'h40, r);
		t0 = cyc;
		do axi_read(A_ONE, d, r); while (d[6] !== 1'b0);
		n = cyc - t0;
		cmp_bit("long settle", 1'b1, n >= 300 * CPM - 2 && n <= 300 * CPM + 15);
		axi_read(A_STAT, d, r);
		cmp_data("irq status long", 32'h1, d);
		$display("TEST long settle done");
		final_report();
	end
endmodule : test_line_trim_control_status
`default_nettype wire
